// *** core/sar_readout.sv ***
// Contract
// RULE_01: strobe rise powers up and puts track-and-hold into tracking.
// RULE_02: strobe fall switches to hold and starts the conversion.
// RULE_03: serial output changes only on serial clock falling edges; code also changes it on strobe rise and at conversion end.
// RULE_04: output driven low at conversion start, MSB shown when done.
// RULE_05: after all bits are shifted out the output goes high impedance.
// RULE_06: twelve bits shifted out, one per serial clock, MSB first.
// RULE_07: two-channel part: positive cap to chosen channel, negative to ground.
// RULE_08: host holds strobe high for the acquisition time, at least 1.4 us.
// RULE_09: power-up completes within 1 us of leaving shutdown.
// RULE_10: first channel: host raises strobe once, holds, then lowers it.
// RULE_11: conversion on internal timing, self shutdown, MSB within 3.7 us.
// RULE_12: host reads all twelve bits before next rise for first channel.
// RULE_13: second channel: high 30 ns, low 30 ns, high, hold, low.
// RULE_14: rise before twelve bits read selects second channel or mode.
// RULE_15: differential part: single pulse unipolar, double pulse bipolar.
// RULE_16: bipolar results two's complement, otherwise straight binary.
// RULE_17: host may read at any serial clock rate up to 8 MHz.
// RULE_18: read completion counted in serial clocks, count cleared on rise.
`timescale 1ns/1ns
`default_nettype none
module sar_readout #(
   parameter bit DIFF_VARIANT = 1'b0  // 1: differential, 0: two-channel
) (
   input  wire logic                      clk_i,            // 100 MHz
   input  wire logic                      resetn_i,         // async, low
   input  wire logic                      convert_strobe_i, // strobe pin
   input  wire logic                      sclk_i,           // serial clock
   input  wire logic [sar_pkg::RES_W-1:0] sample_i,         // offset binary
   output var  logic                      dout_o,           // serial data
   output var  logic                      dout_oe_n_o,      // low = drive
   output var  sar_pkg::sar_afe_t         afe_o             // analog ctrl
);
   import sar_pkg::*;

   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ------------------------------------------------------------------
   // pin edges
   // ------------------------------------------------------------------
   sar_edges_t       strb_e;
   sar_edges_t       sclk_e;
   logic       [1:0] pin_in;
   sar_edges_t [1:0] pin_e;

   // same path for both pins keeps their relative timing intact
   assign pin_in = {sclk_i, convert_strobe_i};

   for (genvar g = 0; g < $bits(pin_in); g++) begin : g_pin
      sar_edge_sync u_sar_edge_sync (
         .clk_i   (clk_i),
         .rst_n_i (rst_n),
         .pin_i   (pin_in[g]),
         .edges_o (pin_e[g])
      );
   end

   assign strb_e = pin_e[0];
   assign sclk_e = pin_e[1];

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // input is offset binary; bipolar flips the sign bit
   function automatic logic [RES_W-1:0] sar_format(
      input logic [RES_W-1:0] s,
      input logic             bip
   );
      sar_format = bip ? {~s[MSB], s[MSB-1:0]} : s;  // RULE_16
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   sar_regs_t r_reg;
   sar_regs_t r_next;
   logic      conv_done;
   logic      sel2;

   assign conv_done = (r_reg.state == ST_CONV) && (r_reg.cnt == CONV_LAST);
   // a rise before the read completed means a second pulse
   assign sel2 = (r_reg.bit_cnt != BITS_ALL);  // RULE_14 RULE_18

   always_comb begin
      r_next = r_reg;
      if (strb_e.rise) begin
         // rise wins over everything, aborting any conversion or read
         r_next.state          = ST_PWRUP;  // RULE_01
         r_next.cnt            = '0;
         r_next.bit_cnt        = '0;  // RULE_18
         r_next.sel_second     = sel2;  // RULE_14
         r_next.dout           = 1'b0;
         r_next.dout_oe_n      = 1'b0;
         r_next.afe.track      = 1'b1;  // RULE_01
         r_next.afe.powered    = 1'b1;
         if (DIFF_VARIANT) begin
            r_next.afe.pos_src = CAP_DIFF;
            r_next.afe.neg_gnd = 1'b0;
            r_next.afe.bipolar = sel2;  // RULE_15
         end else begin
            r_next.afe.pos_src = sel2 ? CAP_SECOND : CAP_FIRST;  // RULE_07
            r_next.afe.neg_gnd = 1'b1;  // RULE_07
            r_next.afe.bipolar = 1'b0;  // RULE_16
         end
      end else begin
         case (r_reg.state)
            ST_PWRUP, ST_TRACK: begin
               if (strb_e.fall) begin
                  r_next.state     = ST_CONV;  // RULE_02
                  r_next.afe.track = 1'b0;  // RULE_02
                  r_next.cnt       = '0;
                  r_next.shreg     = sar_format(sample_i,
                                                r_reg.afe.bipolar);
                  r_next.dout      = 1'b0;  // RULE_04
                  r_next.dout_oe_n = 1'b0;
               end else if (r_reg.state == ST_PWRUP) begin
                  // wake-up is part of the acquisition interval
                  if (r_reg.cnt == PWR_LAST) begin
                     r_next.state = ST_TRACK;  // RULE_09
                  end else begin
                     r_next.cnt = r_reg.cnt + CNT_W'(1);
                  end
               end
            end
            ST_CONV: begin
               if (conv_done) begin
                  r_next.state       = ST_READ;  // RULE_11
                  r_next.afe.powered = 1'b0;  // RULE_11
                  r_next.dout        = r_reg.shreg[MSB];  // RULE_04
               end else begin
                  r_next.cnt = r_reg.cnt + CNT_W'(1);
               end
            end
            ST_READ: begin
               // serial clocks before the MSB is ready are ignored
               if (sclk_e.fall) begin  // RULE_03
                  r_next.bit_cnt = r_reg.bit_cnt + BITCNT_W'(1);  // RULE_18
                  if (r_reg.bit_cnt == BIT_LAST) begin
                     r_next.state     = ST_IDLE;
                     r_next.dout      = 1'b0;
                     r_next.dout_oe_n = 1'b1;  // RULE_05
                  end else begin
                     r_next.dout  = r_reg.shreg[MSB-1];  // RULE_06
                     r_next.shreg = {r_reg.shreg[MSB-1:0], 1'b0};
                  end
               end
            end
            ST_IDLE: begin
               r_next = r_reg;
            end
            default: begin
               r_next = REGS_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= REGS_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign dout_o      = r_reg.dout;
   assign dout_oe_n_o = r_reg.dout_oe_n;
   assign afe_o       = r_reg.afe;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   localparam int A_PWR  = PWR_CYC;
   localparam int A_CONV = CONV_CYC;

   a_rise_track: assert property ( // RULE_01
      @(posedge clk_i) disable iff (!rst_n)
      strb_e.rise |=> (r_reg.afe.track && r_reg.afe.powered
                       && !r_reg.dout_oe_n && !r_reg.dout))
      else $error("strobe rise did not start tracking");

   a_fall_hold: assert property ( // RULE_02
      @(posedge clk_i) disable iff (!rst_n)
      (strb_e.fall && r_reg.afe.track)
      |=> (!r_reg.afe.track && r_reg.state == ST_CONV))
      else $error("strobe fall did not start conversion");

   a_dout_on_fall: assert property ( // RULE_03
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.dout != $past(r_reg.dout))
      |-> ($past(sclk_e.fall) || $past(strb_e.rise) || $past(conv_done)))
      else $error("serial output changed without a cause");

   a_conv_low: assert property ( // RULE_04
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_CONV) |-> (!r_reg.dout && !r_reg.dout_oe_n))
      else $error("serial output not low while converting");

   a_msb_shown: assert property ( // RULE_04
      @(posedge clk_i) disable iff (!rst_n)
      (conv_done && !strb_e.rise)
      |=> (r_reg.dout == $past(r_reg.shreg[MSB]) && !r_reg.dout_oe_n))
      else $error("MSB not presented at conversion end");

   a_release_hiz: assert property ( // RULE_05
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_READ && sclk_e.fall && !strb_e.rise
       && r_reg.bit_cnt == BIT_LAST)
      |=> (r_reg.dout_oe_n && r_reg.state == ST_IDLE))
      else $error("output not released after last bit");

   a_msb_first: assert property ( // RULE_06
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_READ && sclk_e.fall && !strb_e.rise
       && r_reg.bit_cnt != BIT_LAST)
      |=> (r_reg.dout == $past(r_reg.shreg[MSB-1])
           && r_reg.bit_cnt == $past(r_reg.bit_cnt) + BITCNT_W'(1)))
      else $error("wrong bit order on serial output");

   a_cap_route: assert property ( // RULE_07
      @(posedge clk_i) disable iff (!rst_n)
      (!DIFF_VARIANT && r_reg.afe.track)
      |-> (r_reg.afe.neg_gnd && r_reg.afe.pos_src ==
           (r_reg.sel_second ? CAP_SECOND : CAP_FIRST)))
      else $error("sampling capacitors routed wrongly");

   a_pwr_bound: assert property ( // RULE_09
      @(posedge clk_i) disable iff (!rst_n)
      $rose(r_reg.state == ST_PWRUP) |-> ##[1:A_PWR]
      (r_reg.state != ST_PWRUP))
      else $error("power-up took too long");

   a_conv_bound: assert property ( // RULE_11
      @(posedge clk_i) disable iff (!rst_n)
      $rose(r_reg.state == ST_CONV) |-> ##[1:A_CONV]
      (r_reg.state != ST_CONV))
      else $error("conversion took too long");

   a_second_sel: assert property ( // RULE_14
      @(posedge clk_i) disable iff (!rst_n)
      strb_e.rise |=> (r_reg.sel_second ==
                       ($past(r_reg.bit_cnt) != BITS_ALL)))
      else $error("channel selection wrong after rise");

   a_bip_format: assert property ( // RULE_16
      @(posedge clk_i) disable iff (!rst_n)
      (strb_e.fall && r_reg.afe.track && !strb_e.rise)
      |=> (r_reg.shreg == ($past(r_reg.afe.bipolar)
           ? {~$past(sample_i[MSB]), $past(sample_i[MSB-1:0])}
           : $past(sample_i))))
      else $error("result coding wrong");

   a_read_restart: assert property ( // RULE_18
      @(posedge clk_i) disable iff (!rst_n)
      strb_e.rise |=> (r_reg.bit_cnt == '0 && r_reg.state == ST_PWRUP))
      else $error("read count not cleared by strobe rise");

   a_pol_select: assert property ( // RULE_15
      @(posedge clk_i) disable iff (!rst_n)
      strb_e.rise |=> (r_reg.afe.bipolar == (DIFF_VARIANT && $past(sel2))))
      else $error("polarity selection wrong after rise");

   a_diff_route: assert property ( // RULE_07
      @(posedge clk_i) disable iff (!rst_n)
      (DIFF_VARIANT && r_reg.afe.track)
      |-> (!r_reg.afe.neg_gnd && r_reg.afe.pos_src == CAP_DIFF))
      else $error("differential capacitors routed wrongly");

   a_conv_power: assert property ( // RULE_02
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_CONV)
      |-> (r_reg.afe.powered && !r_reg.afe.track))
      else $error("converter not holding while converting");

   a_self_off: assert property ( // RULE_11
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_READ || r_reg.state == ST_IDLE)
      |-> (!r_reg.afe.powered && !r_reg.afe.track))
      else $error("converter still powered after conversion");

   a_idle_hiz: assert property ( // RULE_05
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_IDLE) |-> (r_reg.dout_oe_n && !r_reg.dout))
      else $error("serial output driven while idle");

   a_track_power: assert property ( // RULE_09
      @(posedge clk_i) disable iff (!rst_n)
      (r_reg.state == ST_TRACK)
      |-> (r_reg.afe.powered && r_reg.afe.track && r_reg.cnt == PWR_LAST))
      else $error("tracking entered before power-up finished");

endmodule
`default_nettype wire

// *** core/sar_pkg.sv ***
`default_nettype none
package sar_pkg;

   // ------------------------------------------------------------------
   // sizes and timing
   // ------------------------------------------------------------------
   localparam int RES_W      = 12;
   localparam int CNT_W      = 9;
   localparam int BITCNT_W   = 4;
   localparam int CLK_NS     = 10;
   localparam int PWR_NS     = 1000;
   localparam int CONV_NS    = 3700;
   // pin synchroniser plus edge flop delay the fall seen by the core
   localparam int SYNC_LAT   = 3;
   // longest times round down
   localparam int PWR_CYC    = PWR_NS / CLK_NS;
   localparam int CONV_CYC   = CONV_NS / CLK_NS - SYNC_LAT;

   localparam logic [CNT_W-1:0]    PWR_LAST  = CNT_W'(PWR_CYC - 1);
   localparam logic [CNT_W-1:0]    CONV_LAST = CNT_W'(CONV_CYC - 1);
   localparam logic [BITCNT_W-1:0] BITS_ALL  = BITCNT_W'(RES_W);
   localparam logic [BITCNT_W-1:0] BIT_LAST  = BITCNT_W'(RES_W - 1);
   localparam int                  MSB       = RES_W - 1;

   // ------------------------------------------------------------------
   // positive capacitor source codes
   // ------------------------------------------------------------------
   localparam logic [1:0] CAP_NONE   = 2'h0;
   localparam logic [1:0] CAP_FIRST  = 2'h1;
   localparam logic [1:0] CAP_SECOND = 2'h2;
   localparam logic [1:0] CAP_DIFF   = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_PWRUP = 5'h02,
      ST_TRACK = 5'h04,
      ST_CONV  = 5'h08,
      ST_READ  = 5'h10
   } sar_state_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } sar_edges_t;

   typedef struct packed {
      logic       track;
      logic       powered;
      logic [1:0] pos_src;
      logic       neg_gnd;
      logic       bipolar;
   } sar_afe_t;

   typedef struct packed {
      sar_state_t          state;
      logic [CNT_W-1:0]    cnt;
      logic [BITCNT_W-1:0] bit_cnt;
      logic [RES_W-1:0]    shreg;
      logic                sel_second;
      logic                dout;
      logic                dout_oe_n;
      sar_afe_t            afe;
   } sar_regs_t;

   localparam sar_regs_t REGS_RST = '{
      state:      ST_IDLE,
      cnt:        '0,
      bit_cnt:    BITS_ALL,
      shreg:      '0,
      sel_second: 1'b0,
      dout:       1'b0,
      dout_oe_n:  1'b1,
      afe:        '{track: 1'b0, powered: 1'b0, pos_src: CAP_NONE,
                    neg_gnd: 1'b1, bipolar: 1'b0}
   };

endpackage
`default_nettype wire

// *** core/sar_edge_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_edge_sync (
   input  wire logic          clk_i,    // core clock
   input  wire logic          rst_n_i,  // synchronised reset, active low
   input  wire logic          pin_i,    // asynchronous pin
   output var  sar_pkg::sar_edges_t edges_o  // one-cycle edge pulses
);
   import sar_pkg::*;

   // ------------------------------------------------------------------
   // two sync flops, third flop holds the previous level
   // ------------------------------------------------------------------
   logic [2:0] sh_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_reg <= 3'h0;
      end else begin
         sh_reg <= {sh_reg[1:0], pin_i};
      end
   end

   // only the second and third flops feed the edge logic
   always_comb begin
      edges_o.rise = sh_reg[1] & ~sh_reg[2];
      edges_o.fall = ~sh_reg[1] & sh_reg[2];
   end

endmodule
`default_nettype wire

// *** dv/sar_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_host_model (
   input  wire logic       clk_i,       // core clock, paces the strobe
   input  wire logic [1:0] dout_i,      // data of both devices
   input  wire logic [1:0] dout_oe_n_i, // low = device drives
   output var  logic       strobe_o,    // convert strobe
   output var  logic       sclk_o       // serial clock, low when idle
);
   logic [1:0] line;
   logic       junk;

   // ---------------------------------------------------------------
   // line level
   // ---------------------------------------------------------------
   // no pull on the line: a released wire reads as toggling noise
   initial junk = 1'b0;
   always #5 junk = ~junk;
   assign line[0] = dout_oe_n_i[0] ? junk : dout_i[0];
   assign line[1] = dout_oe_n_i[1] ? ~junk : dout_i[1];

   initial begin
      strobe_o = 1'b0;
      sclk_o   = 1'b0;
   end

   // ---------------------------------------------------------------
   // host actions
   // ---------------------------------------------------------------
   task automatic edge_wait(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // second selection: short high and low pulse first, 50 ns each
   task automatic rise(input bit second);
      if (second) begin
         strobe_o = 1'b1;
         edge_wait(5);
         strobe_o = 1'b0;
         edge_wait(5);
      end
      strobe_o = 1'b1;
   endtask

   task automatic hold(input int acq);
      edge_wait(acq);
      strobe_o = 1'b0;
   endtask

   // 8 MHz; sampled at each rise and again just before the fall
   task automatic read(input int n, output logic [1:0][11:0] w,
                       output logic [1:0][11:0] w2);
      w  = '0;
      w2 = '0;
      for (int i = 0; i < n; i++) begin
         #62 sclk_o = 1'b1;
         w[0][11-i] = line[0];
         w[1][11-i] = line[1];
         #62 w2[0][11-i] = line[0];
         w2[1][11-i] = line[1];
         #1 sclk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** dv/sar_readout_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_readout_tb;
   import sar_pkg::*;
   logic             clk_i;
   logic             resetn_i;
   logic             strobe;
   logic             sclk;
   logic [RES_W-1:0] sample;
   logic [1:0]       dout;
   logic [1:0]       oe_n;
   sar_afe_t         afe_a;
   sar_afe_t         afe_d;
   int               mismatches;
   int               num_checks;
   bit               pend;
   int               sel_t[7] = '{0, 1, 0, 0, 1, 0, 0};
   int               rd_t[7]  = '{12, 12, 5, 12, 0, 12, 12};

   sar_readout #(.DIFF_VARIANT(1'b0)) u_sar_readout (
      .clk_i(clk_i), .resetn_i(resetn_i), .convert_strobe_i(strobe),
      .sclk_i(sclk), .sample_i(sample), .dout_o(dout[0]),
      .dout_oe_n_o(oe_n[0]), .afe_o(afe_a));
   sar_readout #(.DIFF_VARIANT(1'b1)) u_sar_readout_diff (
      .clk_i(clk_i), .resetn_i(resetn_i), .convert_strobe_i(strobe),
      .sclk_i(sclk), .sample_i(sample), .dout_o(dout[1]),
      .dout_oe_n_o(oe_n[1]), .afe_o(afe_d));
   sar_host_model u_sar_host_model (
      .clk_i(clk_i), .dout_i(dout), .dout_oe_n_i(oe_n),
      .strobe_o(strobe), .sclk_o(sclk));

   always #5 clk_i = ~clk_i;

   // ---------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------
   task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_afe(input sar_afe_t got, input sar_afe_t exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_idle();
      check_val(12'({dout, oe_n}), 12'h3);
      check_afe(afe_a, '{1'b0, 1'b0, CAP_NONE, 1'b1, 1'b0});
      check_afe(afe_d, '{1'b0, 1'b0, CAP_NONE, 1'b1, 1'b0});
   endtask

   function automatic sar_afe_t afe_exp(input bit diff, input bit sec);
      afe_exp.track   = 1'b1;
      afe_exp.powered = 1'b1;
      afe_exp.pos_src = diff ? CAP_DIFF : (sec ? CAP_SECOND : CAP_FIRST);
      afe_exp.neg_gnd = !diff;
      afe_exp.bipolar = diff & sec;
   endfunction

   task automatic complete_run();
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // one conversion and a read of n bits
   // ---------------------------------------------------------------
   task automatic convert(input bit sec, input int n);
      logic [1:0][11:0] w, w2;
      logic [11:0]      ea, ed, m;
      bit               s2;
      s2 = sec | pend;
      // decoy while tracking: only the value at the hold point counts
      sample = 12'($urandom);
      m = 12'(13'h1FFF << (12 - n));
      u_sar_host_model.rise(sec);
      u_sar_host_model.edge_wait(8);
      check_afe(afe_a, afe_exp(1'b0, s2));
      check_afe(afe_d, afe_exp(1'b1, s2));
      check_val(12'({dout, oe_n}), 12'h0);
      sample = 12'($urandom);
      ea = sample;
      ed = s2 ? {~sample[11], sample[10:0]} : sample;
      u_sar_host_model.hold(150);
      u_sar_host_model.edge_wait(8);
      // late change exposes a sample taken after the hold point
      sample = 12'($urandom);
      check_val(12'({afe_a.track, afe_a.powered, afe_d.track,
                     afe_d.powered}), 12'h5);
      u_sar_host_model.edge_wait(290);
      check_val(12'({dout, oe_n}), 12'h0);
      // lands exactly 3.7 us after the strobe fall
      u_sar_host_model.edge_wait(72);
      check_val(12'({dout, oe_n, afe_a.powered, afe_d.powered}),
                12'({ed[11], ea[11], 4'h0}));
      u_sar_host_model.read(n, w, w2);
      check_val(w[0], ea & m);
      check_val(w[1], ed & m);
      check_val(w2[0], ea & m);
      check_val(w2[1], ed & m);
      u_sar_host_model.edge_wait(6);
      check_val(12'(oe_n), (n == 12) ? 12'h3 : 12'h0);
      pend = (n != 12);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      resetn_i = 1'b0;
      sample = '0;
      mismatches = 0;
      num_checks = 0;
      pend = 1'b0;
      void'($urandom(67));
      repeat (6) @(posedge clk_i);
      #1 resetn_i = 1'b1;
      u_sar_host_model.edge_wait(10);
      check_idle();
      for (int i = 0; i < 7; i++)
         convert(sel_t[i][0], rd_t[i]);
      // reset while tracking; strobe dropped before release
      u_sar_host_model.rise(1'b0);
      u_sar_host_model.edge_wait(20);
      resetn_i = 1'b0;
      u_sar_host_model.hold(2);
      u_sar_host_model.edge_wait(4);
      resetn_i = 1'b1;
      u_sar_host_model.edge_wait(10);
      check_idle();
      pend = 1'b0;
      repeat (6)
         convert($urandom % 2, ($urandom % 3 == 0) ? $urandom % 12 : 12);
      complete_run();
   end

   // hang guard, about ten times the expected run time
   initial begin
      #900000;
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
